// ### rtl/scs_defines.svh
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SCS_CLK_HZ 100000000
`define SCS_CLK_NS 10
`define SCS_SETUP_NS 10
`define SCS_SETUP_CYC \
  ((`SCS_SETUP_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_ACQ_NS 400
`define SCS_ACQ_CYC ((`SCS_ACQ_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_QUIET_NS 200
`define SCS_QUIET_CYC \
  ((`SCS_QUIET_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_SETTLE_MS 70
`define SCS_SETTLE_CYC (`SCS_SETTLE_MS * (`SCS_CLK_HZ / 1000))
`define SCS_MCLK_HZ 4000000
`define SCS_MCLK_DIV (`SCS_CLK_HZ / `SCS_MCLK_HZ)
`define SCS_START_LOW_CYC 2
`define SCS_BUS_CYC 3

// ****************************************
// Conversion length in master clock half periods
// ****************************************
`define SCS_HALF_FAST 10'd33
`define SCS_HALF_SLOW 10'd35
`define SCS_HALF_CAL 10'd400

// ****************************************
// Register map and fields
// ****************************************
`define SCS_ADDR_CTRL 2'h0
`define SCS_ADDR_STATUS 2'h1
`define SCS_ADDR_RESULT 2'h2
`define SCS_ADDR_GAIN 2'h3
`define SCS_CTRL_START_BIT 0
`define SCS_STAT_BUSY_BIT 4
`define SCS_STAT_CAL_BIT 0
`define SCS_GAIN_BITS 14
`define SCS_GAIN_RESET 14'h2000

`endif

// ### rtl/scs_pkg.sv
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_DEV_IDLE = 2'b00,
    SCS_DEV_WAIT = 2'b01,
    SCS_DEV_CONV = 2'b10,
    SCS_DEV_CAL = 2'b11
  } scs_dev_state_type;

  typedef enum logic [2:0] {
    SCS_HOST_IDLE = 3'b000,
    SCS_HOST_BUS = 3'b001,
    SCS_HOST_QUIET = 3'b010,
    SCS_HOST_PULSE = 3'b011,
    SCS_HOST_CONV = 3'b100
  } scs_host_state_type;

  typedef logic [15:0] scs_word_type;
endpackage

// ### rtl/scs_if.sv
`timescale 1ns/1ps
interface scs_if;
  logic conversion_start_n;
  logic master_clock_input;
  logic busy;
  logic track_hold;
  logic bus_cs_n;
  logic bus_wr_n;
  logic bus_rd_n;
  logic [1:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;

  // Device end: converter sequencer
  modport dev (
    input conversion_start_n,
    input master_clock_input,
    output busy,
    output track_hold,
    input bus_cs_n,
    input bus_wr_n,
    input bus_rd_n,
    input bus_addr,
    input bus_wdata,
    output bus_rdata
  );

  // Host end: processor bus and clock source
  modport host (
    output conversion_start_n,
    output master_clock_input,
    input busy,
    input track_hold,
    output bus_cs_n,
    output bus_wr_n,
    output bus_rd_n,
    output bus_addr,
    output bus_wdata,
    input bus_rdata
  );
endinterface

// ### rtl/scs_gain_scale.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_gain_scale (
  input wire logic [11:0] raw_code,
  input wire logic [13:0] gain,
  output logic [11:0] scaled_code
);
  import scs_pkg::*;
  logic signed [14:0] gain_diff;
  logic signed [27:0] prod;
  logic signed [40:0] wide;
  logic signed [10:0] corr;
  logic signed [14:0] total;

  // ****************************************
  // Result scaling by gain
  // ****************************************
  // Factor is 1 + (gain - nominal) * 0.025 / 8192; 3277 / 2^30 stands
  // in for 1 / 327680 so no divider is needed; half a step is added
  // before the cut so the small excess of that ratio cannot pull a
  // negative correction one code too low
  always_comb
  begin
    gain_diff = $signed({1'b0, gain}) - $signed({1'b0, `SCS_GAIN_RESET});
    prod = $signed({1'b0, raw_code}) * gain_diff;
    wide = $signed({{13{prod[27]}}, prod}) * 41'sd3277 + 41'sd536870912;
    corr = wide[40:30];
    // Larger gain lifts the code, smaller lowers it
    total = $signed({3'b000, raw_code}) + $signed({{4{corr[10]}}, corr});
    // Clamp keeps the full 0.975..1.025 span in code range
    if (total < 15'sd0)
      scaled_code = 12'h000;
    else if (total > 15'sd4095)
      scaled_code = 12'hfff;
    else
      scaled_code = total[11:0];
  end
endmodule

// ### rtl/scs_device.sv
//Contract
// - Start by pin pulse or control bit
// - Start edge or write end enters hold
// - Convert from next master falling edge
// - Setup met: 16.5 master periods
// - Setup missed: 17.5 master periods
// - Completion drops busy, result readable
// - Host stays off bus near conversion
// - Busy fall clears software start bit
// - Host write ends after busy falls
// - First start runs self-calibration
// - Host waits 70 ms after first start
// - Busy fall returns to tracking
// - Host allows 400 ns acquisition
// - Gain register 14 bits, top zero
// - Gain MSB weighs 2.5 percent
// - Larger gain compensates smaller range
// - Gain corrects 0.975 to 1.025 range
// - Host supplies 4 MHz master clock
// - Host allows 1.5 periods acquisition
// - Status busy bit shows activity
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_device (
  input wire logic clk_sys,
  input wire logic resetn,
  scs_if.dev link,
  input wire logic [11:0] sample_code,
  output logic result_valid,
  output scs_pkg::scs_word_type result_data,
  output logic cal_done
);
  import scs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  scs_dev_state_type state_reg, state_next;
  logic [9:0] edge_cnt_reg, edge_cnt_next;
  logic [9:0] target_reg, target_next;
  logic [3:0] wait_cnt_reg, wait_cnt_next;
  logic cal_done_reg, cal_done_next;
  logic busy_reg, busy_next;
  logic hold_reg, hold_next;
  logic sw_start_reg, sw_start_next;
  logic [13:0] gain_reg, gain_next;
  logic [11:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic [15:0] rdata_reg, rdata_next;
  logic mclk_prev_reg;
  logic start_prev_reg;
  logic wr_prev_reg;
  logic wr_sel_reg, wr_sel_next;
  logic [1:0] wr_addr_reg, wr_addr_next;
  logic [15:0] wr_data_reg, wr_data_next;
  logic [11:0] scaled;

  logic pin_rise;
  logic wr_end;
  logic sw_set;
  logic start_evt;
  logic mclk_fall;
  logic mclk_edge;
  logic [15:0] gain_word;

  // ****************************************
  // Gain scaling
  // ****************************************
  scs_gain_scale scs_gain_scale_inst (
    .raw_code(sample_code),
    .gain(gain_reg),
    .scaled_code(scaled)
  );

  // ****************************************
  // Edge detection
  // ****************************************
  // Inputs are synchronous to clk_sys, so one stage per edge is enough
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mclk_prev_reg <= 1'b0;
      start_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end
    else
    begin
      mclk_prev_reg <= link.master_clock_input;
      start_prev_reg <= link.conversion_start_n;
      wr_prev_reg <= link.bus_wr_n;
    end
  end

  // Event terms
  assign pin_rise = link.conversion_start_n & ~start_prev_reg;
  assign wr_end = link.bus_wr_n & ~wr_prev_reg & wr_sel_reg;
  assign sw_set = wr_end && (wr_addr_reg == `SCS_ADDR_CTRL)
    && wr_data_reg[`SCS_CTRL_START_BIT];
  // Both start sources funnel into one event
  assign start_evt = pin_rise | sw_set;
  assign mclk_fall = mclk_prev_reg & ~link.master_clock_input;
  assign mclk_edge = mclk_prev_reg ^ link.master_clock_input;
  // Top two bits always read zero
  assign gain_word = {2'b00, gain_reg};

  // ****************************************
  // Register bus: write capture and commit
  // ****************************************
  // Write is latched while strobe is low and acted on at its end,
  // since the start timing counts from the strobe rising edge
  always_comb
  begin
    wr_sel_next = wr_sel_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    if (!link.bus_wr_n && !link.bus_cs_n)
    begin
      wr_sel_next = 1'b1;
      wr_addr_next = link.bus_addr;
      wr_data_next = link.bus_wdata;
    end
    else if (link.bus_wr_n)
      wr_sel_next = 1'b0;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    edge_cnt_next = edge_cnt_reg;
    target_next = target_reg;
    wait_cnt_next = wait_cnt_reg;
    cal_done_next = cal_done_reg;
    busy_next = busy_reg;
    hold_next = hold_reg;
    sw_start_next = sw_start_reg;
    gain_next = gain_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    if (wr_end && wr_addr_reg == `SCS_ADDR_GAIN)
      gain_next = wr_data_reg[13:0];
    case (state_reg)
      SCS_DEV_IDLE:
      begin
        if (start_evt)
        begin
          busy_next = 1'b1;
          hold_next = 1'b1;
          sw_start_next = sw_set | sw_start_reg;
          edge_cnt_next = 10'd0;
          wait_cnt_next = 4'd1;
          if (!cal_done_reg)
          begin
            // First start after reset calibrates instead
            state_next = SCS_DEV_CAL;
          end
          else if (mclk_fall)
          begin
            // Edge in the start cycle misses setup
            target_next = `SCS_HALF_SLOW;
            state_next = SCS_DEV_CONV;
          end
          else
            state_next = SCS_DEV_WAIT;
        end
      end
      SCS_DEV_WAIT:
      begin
        if (wait_cnt_reg != 4'hf)
          wait_cnt_next = wait_cnt_reg + 4'd1;
        if (mclk_fall)
        begin
          // Next falling edge begins conversion
          state_next = SCS_DEV_CONV;
          if (32'(wait_cnt_reg) >= `SCS_SETUP_CYC)
            target_next = `SCS_HALF_FAST;
          else
            target_next = `SCS_HALF_SLOW;
        end
      end
      SCS_DEV_CONV, SCS_DEV_CAL:
      begin
        if (mclk_edge)
          edge_cnt_next = edge_cnt_reg + 10'd1;
        if (mclk_edge && ((state_reg == SCS_DEV_CONV
          && edge_cnt_reg + 10'd1 == target_reg)
          || (state_reg == SCS_DEV_CAL
          && edge_cnt_reg + 10'd1 == `SCS_HALF_CAL)))
        begin
          state_next = SCS_DEV_IDLE;
          busy_next = 1'b0;
          hold_next = 1'b0;
          sw_start_next = 1'b0;
          if (state_reg == SCS_DEV_CAL)
          begin
            cal_done_next = 1'b1;
            gain_next = `SCS_GAIN_RESET;
          end
          else
          begin
            result_next = scaled;
            valid_next = 1'b1;
          end
        end
      end
      default:
        state_next = SCS_DEV_IDLE;
    endcase
    // Starts during an active run fall through untouched
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= SCS_DEV_IDLE;
      edge_cnt_reg <= 10'd0;
      target_reg <= `SCS_HALF_FAST;
      wait_cnt_reg <= 4'd0;
      cal_done_reg <= 1'b0;
      busy_reg <= 1'b0;
      hold_reg <= 1'b0;
      sw_start_reg <= 1'b0;
      gain_reg <= `SCS_GAIN_RESET;
      result_reg <= 12'h000;
      valid_reg <= 1'b0;
      wr_sel_reg <= 1'b0;
      wr_addr_reg <= 2'h0;
      wr_data_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      target_reg <= target_next;
      wait_cnt_reg <= wait_cnt_next;
      cal_done_reg <= cal_done_next;
      busy_reg <= busy_next;
      hold_reg <= hold_next;
      sw_start_reg <= sw_start_next;
      gain_reg <= gain_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
      wr_sel_reg <= wr_sel_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // ****************************************
  // Register bus: read data
  // ****************************************
  always_comb
  begin
    rdata_next = 16'h0000;
    if (!link.bus_rd_n && !link.bus_cs_n)
    begin
      case (link.bus_addr)
        `SCS_ADDR_CTRL:
          rdata_next[`SCS_CTRL_START_BIT] = sw_start_reg;
        `SCS_ADDR_STATUS:
        begin
          rdata_next[`SCS_STAT_BUSY_BIT] = busy_reg;
          rdata_next[`SCS_STAT_CAL_BIT] = (state_reg == SCS_DEV_CAL);
        end
        `SCS_ADDR_RESULT:
          rdata_next = {4'h0, result_reg};
        `SCS_ADDR_GAIN:
          rdata_next = gain_word;
        default:
          rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.busy = busy_reg;
  assign link.track_hold = hold_reg;
  assign link.bus_rdata = rdata_reg;
  assign result_valid = valid_reg;
  assign result_data = {4'h0, result_reg};
  assign cal_done = cal_done_reg;
endmodule

// ### rtl/scs_host.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_host #(
  parameter int unsigned SETTLE_CYC = `SCS_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  scs_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_addr,
  input wire scs_pkg::scs_word_type cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output scs_pkg::scs_word_type rsp_rdata
);
  import scs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  scs_host_state_type state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] gap_reg, gap_next;
  logic [4:0] div_reg, div_next;
  logic mclk_reg, mclk_next;
  logic first_reg, first_next;
  logic start_n_reg, start_n_next;
  logic cs_n_reg, cs_n_next;
  logic wr_n_reg, wr_n_next;
  logic rd_n_reg, rd_n_next;
  logic is_wr_reg, is_wr_next;
  logic [1:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [15:0] rsp_reg, rsp_next;
  logic busy_prev_reg;
  logic busy_fall;

  assign busy_fall = busy_prev_reg & ~link.busy;

  // ****************************************
  // Master clock divider: 4 MHz
  // ****************************************
  always_comb
  begin
    div_next = div_reg + 5'd1;
    if (32'(div_reg) == `SCS_MCLK_DIV - 1)
      div_next = 5'd0;
    mclk_next = (32'(div_next) < `SCS_MCLK_DIV / 2);
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    gap_next = gap_reg;
    first_next = first_reg;
    start_n_next = 1'b1;
    cs_n_next = 1'b1;
    wr_n_next = 1'b1;
    rd_n_next = 1'b1;
    is_wr_next = is_wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rsp_valid_next = 1'b0;
    rsp_next = rsp_reg;
    // Acquisition and settle gap counts down after each busy fall
    if (gap_reg != 32'd0)
      gap_next = gap_reg - 32'd1;
    case (state_reg)
      SCS_HOST_IDLE:
      begin
        if (cmd_valid && gap_reg == 32'd0)
        begin
          cnt_next = 32'd0;
          is_wr_next = cmd_write;
          addr_next = cmd_addr;
          wdata_next = cmd_wdata;
          state_next = cmd_start ? SCS_HOST_QUIET : SCS_HOST_BUS;
        end
      end
      SCS_HOST_BUS:
      begin
        cnt_next = cnt_reg + 32'd1;
        cs_n_next = 1'b0;
        wr_n_next = ~is_wr_reg;
        rd_n_next = is_wr_reg;
        if (cnt_reg == `SCS_BUS_CYC - 1)
        begin
          cs_n_next = 1'b1;
          wr_n_next = 1'b1;
          rd_n_next = 1'b1;
          rsp_valid_next = ~is_wr_reg;
          rsp_next = link.bus_rdata;
          // A software start write waits for busy to fall
          state_next = (is_wr_reg && addr_reg == `SCS_ADDR_CTRL
            && wdata_reg[`SCS_CTRL_START_BIT])
            ? SCS_HOST_CONV : SCS_HOST_IDLE;
        end
      end
      SCS_HOST_QUIET:
      begin
        // Bus idle ahead of the start edge
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg == `SCS_QUIET_CYC - 1)
        begin
          cnt_next = 32'd0;
          state_next = SCS_HOST_PULSE;
        end
      end
      SCS_HOST_PULSE:
      begin
        cnt_next = cnt_reg + 32'd1;
        start_n_next = 1'b0;
        if (cnt_reg == `SCS_START_LOW_CYC - 1)
        begin
          start_n_next = 1'b1;
          state_next = SCS_HOST_CONV;
        end
      end
      SCS_HOST_CONV:
      begin
        // No bus traffic until busy falls
        if (busy_fall)
        begin
          state_next = SCS_HOST_IDLE;
          // 400 ns covers the 1.5 period minimum too
          // and the acquisition share of a full cycle
          gap_next = first_reg ? 32'(SETTLE_CYC) : `SCS_ACQ_CYC;
          first_next = 1'b0;
        end
      end
      default:
        state_next = SCS_HOST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= SCS_HOST_IDLE;
      cnt_reg <= 32'd0;
      gap_reg <= 32'd0;
      div_reg <= 5'd0;
      mclk_reg <= 1'b0;
      first_reg <= 1'b1;
      start_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      is_wr_reg <= 1'b0;
      addr_reg <= 2'h0;
      wdata_reg <= 16'h0000;
      rsp_valid_reg <= 1'b0;
      rsp_reg <= 16'h0000;
      busy_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      gap_reg <= gap_next;
      div_reg <= div_next;
      mclk_reg <= mclk_next;
      first_reg <= first_next;
      start_n_reg <= start_n_next;
      cs_n_reg <= cs_n_next;
      wr_n_reg <= wr_n_next;
      rd_n_reg <= rd_n_next;
      is_wr_reg <= is_wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg <= rsp_next;
      busy_prev_reg <= link.busy;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.conversion_start_n = start_n_reg;
  assign link.master_clock_input = mclk_reg;
  assign link.bus_cs_n = cs_n_reg;
  assign link.bus_wr_n = wr_n_reg;
  assign link.bus_rd_n = rd_n_reg;
  assign link.bus_addr = addr_reg;
  assign link.bus_wdata = wdata_reg;
  assign cmd_ready = (state_reg == SCS_HOST_IDLE) && (gap_reg == 32'd0);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_reg;
endmodule

// ### test/scs_seq_props.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_seq_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic track_hold,
  input wire logic bus_cs_n,
  input wire logic bus_wr_n,
  input wire logic bus_rd_n,
  input wire logic [1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ****************
  // Helper counters
  // ****************
  logic [12:0] busy_cnt_reg, busy_cnt_next;
  logic [12:0] idle_cnt_reg, idle_cnt_next;
  logic [12:0] quiet_cnt_reg, quiet_cnt_next;
  logic ran_reg, ran_next;

  // Idle and quiet counters saturate so long idle spells never wrap
  always_comb
  begin
    busy_cnt_next = busy ? busy_cnt_reg + 13'h1 : 13'h0;
    idle_cnt_next = busy ? 13'h0 : idle_cnt_reg + {12'h0, ~&idle_cnt_reg};
    quiet_cnt_next = bus_cs_n ? quiet_cnt_reg + {12'h0, ~&quiet_cnt_reg}
                              : 13'h0;
    ran_next = ran_reg | (busy_cnt_reg != 13'h0 && !busy);
  end

  // Idle and quiet start full: no run has yet ended
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_cnt_reg <= 13'h0;
      idle_cnt_reg <= 13'h1fff;
      quiet_cnt_reg <= 13'h1fff;
      ran_reg <= 1'b0;
    end
    else
    begin
      busy_cnt_reg <= busy_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
      quiet_cnt_reg <= quiet_cnt_next;
      ran_reg <= ran_next;
    end
  end

  // ****************
  // Start events
  // ****************
  sequence s_pin_rise;
    $rose(conversion_start_n);
  endsequence
  sequence s_commit;
    $rose(bus_wr_n) && !$past(bus_cs_n) &&
      $past(bus_addr) == `SCS_ADDR_CTRL && $past(bus_wdata[0]);
  endsequence
  sequence s_any_start;
    s_pin_rise or s_commit;
  endsequence

  // ****************
  // Properties
  // ****************
  chk_hold_tracks_busy: assert property (
    track_hold == busy)
    else $error("track hold differs from busy");
  chk_start_sets_busy: assert property (
    s_any_start ##0 !busy |=> busy)
    else $error("start did not raise busy");
  // Busy may only rise one cycle after a pin rise or a strobe end
  chk_busy_has_cause: assert property (
    $rose(busy) |->
    ($past(conversion_start_n) && !$past(conversion_start_n, 2))
    || ($past(bus_wr_n) && !$past(bus_wr_n, 2)))
    else $error("busy rose without start");
  chk_conv_span_ok: assert property (
    $fell(busy) && ran_reg |->
    busy_cnt_reg >= 405 && busy_cnt_reg <= 450)
    else $error("conversion length out of range");
  chk_cal_span_ok: assert property (
    $fell(busy) && !ran_reg |->
    busy_cnt_reg >= 4970 && busy_cnt_reg <= 5060)
    else $error("calibration length out of range");
  chk_bus_quiet_busy: assert property (
    busy && $past(busy, 2) |-> bus_cs_n)
    else $error("bus access during conversion");
  chk_quiet_before: assert property (
    s_pin_rise |-> quiet_cnt_reg >= 20)
    else $error("bus access too close to start");
  chk_acq_gap_ok: assert property (
    $fell(conversion_start_n) |-> idle_cnt_reg >= 40)
    else $error("acquisition gap too short");
  chk_status_busy_bit: assert property (
    !bus_cs_n && !bus_rd_n && bus_addr == `SCS_ADDR_STATUS |=>
    bus_rdata[`SCS_STAT_BUSY_BIT] == $past(busy))
    else $error("status busy bit wrong");
  chk_gain_top_zero: assert property (
    !bus_cs_n && !bus_rd_n && bus_addr == `SCS_ADDR_GAIN |=>
    bus_rdata[15:14] == 2'b00)
    else $error("gain top bits not zero");
  chk_ctrl_idle_clear: assert property (
    !bus_cs_n && !bus_rd_n && !busy && bus_addr == `SCS_ADDR_CTRL |=>
    bus_rdata[0] == 1'b0)
    else $error("start bit not cleared");
endmodule

// ### test/test_sar_conversion_sequencer.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
module test_sar_conversion_sequencer;
  import scs_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] sample_code = 12'h000;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_write = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  scs_word_type cmd_wdata = 16'h0000;
  logic result_valid, cal_done, cmd_ready, rsp_valid;
  scs_word_type result_data, rsp_rdata, rd, g;
  logic [11:0] e;
  int err_count = 0;
  int samples_checked = 0;
  int res_count = 0;
  int n, m, k;

  // ****************
  // Clock and parts
  // ****************
  always #5 clk_sys = ~clk_sys;
  scs_if link_if ();
  scs_device scs_device_inst (.clk_sys(clk_sys), .resetn(resetn),
    .link(link_if), .sample_code(sample_code),
    .result_valid(result_valid), .result_data(result_data),
    .cal_done(cal_done));
  // Short settle keeps the run brief
  scs_host #(.SETTLE_CYC(200)) scs_host_inst (.clk_sys(clk_sys),
    .resetn(resetn), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_start(cmd_start), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  scs_seq_props scs_seq_props_inst (.clk_sys(clk_sys), .resetn(resetn),
    .conversion_start_n(link_if.conversion_start_n), .busy(link_if.busy),
    .track_hold(link_if.track_hold), .bus_cs_n(link_if.bus_cs_n),
    .bus_wr_n(link_if.bus_wr_n), .bus_rd_n(link_if.bus_rd_n),
    .bus_addr(link_if.bus_addr), .bus_wdata(link_if.bus_wdata),
    .bus_rdata(link_if.bus_rdata));

  // Count result pulses, calibration must give none
  always @(posedge clk_sys)
    if (result_valid === 1'b1)
      res_count <= res_count + 1;

  // ****************
  // Tasks
  // ****************
  task check(input scs_word_type seen, input scs_word_type exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One host command; a read leaves its data in rd
  task host_op(input logic s, input logic w, input logic [1:0] a,
               input scs_word_type d);
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 20000)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_start <= s;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    if (!s && !w)
    begin
      while (rsp_valid !== 1'b1 && n < 20)
      begin
        @(negedge clk_sys);
        n++;
      end
      rd = rsp_rdata;
    end
  endtask

  // Exact grid: raw 1280*m and gain 8192+256*k give raw+m*k
  function automatic logic [11:0] exp_code(input int mm, input int kk);
    int v;
    v = 1280 * mm + mm * kk;
    if (v > 4095)
      v = 4095;
    if (v < 0)
      v = 0;
    return 12'(v);
  endfunction

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    void'($urandom(30));
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    host_op(1'b0, 1'b0, `SCS_ADDR_GAIN, 16'h0000);
    check(rd, 16'h2000);
    host_op(1'b0, 1'b0, `SCS_ADDR_STATUS, 16'h0000);
    check(rd & 16'h0011, 16'h0000);
    host_op(1'b1, 1'b0, 2'h0, 16'h0000);
    n = 0;
    while (cal_done !== 1'b1 && n < 8000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check({15'h0, cal_done}, 16'h0001);
    check(16'(res_count), 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      m = (i == 0) ? 3 : $urandom_range(3, 0);
      k = $urandom_range(63, 0);
      k = (i == 0) ? 31 : (i == 1) ? -32 : k - 32;
      g = {2'($urandom_range(3, 0)), 14'(8192 + 256 * k)};
      e = exp_code(m, k);
      host_op(1'b0, 1'b1, `SCS_ADDR_GAIN, g);
      host_op(1'b0, 1'b0, `SCS_ADDR_GAIN, 16'h0000);
      check(rd, {2'b00, g[13:0]});
      @(posedge clk_sys);
      sample_code <= 12'(1280 * m);
      if (i[0])
        host_op(1'b1, 1'b0, 2'h0, 16'h0000);
      else
        host_op(1'b0, 1'b1, `SCS_ADDR_CTRL, 16'h0001);
      n = 0;
      while (result_valid !== 1'b1 && n < 1500)
      begin
        @(negedge clk_sys);
        n++;
      end
      check(result_data, {4'h0, e});
      host_op(1'b0, 1'b0, `SCS_ADDR_RESULT, 16'h0000);
      check(rd & 16'h0fff, {4'h0, e});
      host_op(1'b0, 1'b0, `SCS_ADDR_CTRL, 16'h0000);
      check(rd & 16'h0001, 16'h0000);
    end
    conclude;
  end

  // Whole run needs about 10000 cycles; cut off at 40000
  initial
  begin
    #400000;
    err_count++;
    conclude;
  end
endmodule
